// ---- include/lsac_map.vh ----
// Constants for the load/store access checker: encodings, codes, sizes.
// Assumes inclusion by bare name from the design files.
`ifndef LSAC_MAP_VH
`define LSAC_MAP_VH

// Access kinds
`define LSAC_KIND_LD_DATA   4'h0
`define LSAC_KIND_ST_DATA   4'h1
`define LSAC_KIND_LD_ADDR   4'h2
`define LSAC_KIND_ST_ADDR   4'h3
`define LSAC_KIND_LMS       4'h4
`define LSAC_KIND_SWAP      4'h5
`define LSAC_KIND_BIT_ST    4'h6
`define LSAC_KIND_CTX_LD    4'h7
`define LSAC_KIND_CTX_ST    4'h8

// Access sizes
`define LSAC_SIZE_BYTE      2'h0
`define LSAC_SIZE_HALF      2'h1
`define LSAC_SIZE_WORD      2'h2
`define LSAC_SIZE_DBL       2'h3

// Addressing modes
`define LSAC_MODE_ABS       3'h0
`define LSAC_MODE_SHORT     3'h1
`define LSAC_MODE_LONG      3'h2
`define LSAC_MODE_PRE       3'h3
`define LSAC_MODE_POST      3'h4
`define LSAC_MODE_CIRC      3'h5
`define LSAC_MODE_BREV      3'h6

// Trap causes
`define LSAC_TRAP_NONE      3'h0
`define LSAC_TRAP_MEM       3'h1
`define LSAC_TRAP_ALN       3'h2
`define LSAC_TRAP_PRIV      3'h3
`define LSAC_TRAP_PROT      3'h4
`define LSAC_TRAP_MMU       3'h5

// Privilege levels
`define LSAC_PRIV_USER0     2'h0
`define LSAC_PRIV_USER1     2'h1
`define LSAC_PRIV_SUPER     2'h2

// Segment map
`define LSAC_SEG_LAST_VIRT  4'h7
`define LSAC_SEG_PERIPH_LO  4'hE
`define LSAC_SEG_PERIPH_NS  4'hF

// Alignment masks on the low address bits
`define LSAC_ALN_HALF       6'h01
`define LSAC_ALN_WORD       6'h03
`define LSAC_ALN_CTX        6'h3F

// Context block: sixteen words, four bytes apart
`define LSAC_CTX_LAST       4'hF
`define LSAC_WORD_STEP      32'h00000004

`endif

// ---- design/lsac_extend.v ----
// Fills a loaded byte, half-word or fraction out to register width.
// Assumes raw data arrives little-endian in the low bytes.
`timescale 1ns/1ps
`include "lsac_map.vh"

module lsac_extend (
  // Raw load data and its shape
  input  wire [63:0] rawData,
  input  wire [1:0]  accSize,
  input  wire        signExt,
  input  wire        fracLoad,
  // Register-ready value
  output reg  [63:0] extData
);

  always @* begin
    case (accSize)
      `LSAC_SIZE_BYTE: begin
        extData = {{56{signExt & rawData[7]}}, rawData[7:0]}; // [R3]
      end
      `LSAC_SIZE_HALF: begin
        if (fracLoad) begin
          // Sign bit lands in bit 31, binary point just below it
          extData = {32'h00000000, rawData[15:0], 16'h0000}; // [R4]
        end else begin
          extData = {{48{signExt & rawData[15]}}, rawData[15:0]}; // [R3]
        end
      end
      `LSAC_SIZE_WORD: begin
        extData = {32'h00000000, rawData[31:0]};
      end
      default: begin
        extData = rawData;
      end
    endcase
  end

endmodule // lsac_extend

// ---- design/lsac_access_check.v ----
// Load/store access checker: address forming, access checks, bus sequencing.
// Assumes a pipeline holding request inputs stable while reqValid is high,
// and a bus that answers each busReq with a one-cycle busAck.
//
// What this block does
// [R1] Booleans made are 1 or 0; a tested boolean word counts when non-zero.
// [R2] Addresses are 32-bit unsigned; no sign is ever applied to them.
// [R3] Byte and half-word loads are sign- or zero-extended per operation.
// [R4] Fractions keep sign on top, binary point next; range minus one to one.
// [R5] Address-register word and double-word transfers need four-byte alignment.
// [R6] Data loads/stores need two-byte alignment; byte ops and bit store any.
// [R7] Masked modify-store and swap need a word-aligned operand.
// [R8] Double-word accesses to peripheral segments need word alignment.
// [R9] Context transfers of sixteen words need 64-byte alignment.
// [R10] Memory and registers are little-endian, low byte at low address.
// [R11] Top four address bits pick one of sixteen 256-megabyte segments.
// [R12] Absolute addresses reach only the first 16 kilobytes of a segment.
// [R13] Displacement crossing a segment boundary aborts with a memory trap.
// [R14] Segments 0-7 are virtual under an enabled MMU; may trap without one.
// [R15] Segments E and F are peripheral; F is non-speculative, not user-0.
// [R16] Core special registers sit in one 64-kilobyte window, base set here.
// [R17] Masked modify-store writes mask-selected bits, returns nothing.
// [R18] Swap exchanges register and memory word atomically.
// [R19] With protection on, atomics need read and write permission.
// [R20] Seven addressing modes: none, one or a pair of address registers.
// [R21] Misaligned accesses never reach the bus and raise an alignment trap, or a memory trap if they also cross a segment.
`timescale 1ns/1ps
`include "lsac_map.vh"

module lsac_access_check #(
  parameter        MMU_PRESENT = 1'b1,
  parameter        NOMMU_TRAP  = 1'b0,
  parameter [15:0] CORE_SPECIAL_REGISTERS_BASE   = 16'hF000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Request from the pipeline
  input  wire        reqValid,
  input  wire [3:0]  reqKind,
  input  wire [1:0]  reqSize,
  input  wire [2:0]  reqMode,
  input  wire        reqSigned,
  input  wire        reqFrac,
  input  wire        reqSpec,
  input  wire [31:0] reqBase,
  input  wire [15:0] reqOffset,
  input  wire [15:0] reqIndex,
  input  wire [17:0] reqAbs,
  input  wire [63:0] reqData,
  input  wire [31:0] reqMask,
  input  wire [31:0] reqBitSrc,
  input  wire [2:0]  reqBitPos,
  input  wire [31:0] ctxData,
  // Core state
  input  wire [1:0]  privMode,
  input  wire        mmuEnable,
  input  wire        protEnable,
  input  wire        protRead,
  input  wire        protWrite,
  // Answer to the pipeline
  output reg         reqReady_q,
  output reg         respValid_q,
  output reg         respWrite_q,
  output reg  [63:0] respData_q,
  output reg  [31:0] respBase_q,
  output reg  [3:0]  ctxIndex_q,
  output reg         respRetry_q,
  output reg         trapValid_q,
  output reg  [2:0]  trapCause_q,
  // Memory and peripheral bus
  output reg         busReq_q,
  output reg         busWe_q,
  output reg  [31:0] busAddr_q,
  output reg  [1:0]  busSize_q,
  output reg  [63:0] busWdata_q,
  output reg         busLock_q,
  output reg         busNonSpec_q,
  output reg         busVirtual_q,
  output reg         busCsfr_q,
  input  wire        busAck,
  input  wire [63:0] busRdata
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_READ  = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  reg  [1:0]  state_q;
  reg  [3:0]  kind_q;
  reg  [1:0]  size_q;
  reg         signed_q;
  reg         frac_q;
  reg  [63:0] src_q;
  reg  [31:0] mask_q;
  reg         bitVal_q;
  reg  [2:0]  bitPos_q;

  reg  [31:0] effAddr;
  reg  [31:0] newBase;
  reg         usesDisp;
  reg         alnBad;
  wire [31:0] shortOff;
  wire [31:0] longOff;
  wire [3:0]  reqSeg;
  wire        isAtomic;
  wire        isCtx;
  wire        isLoad;
  wire        crossTrap;
  wire        privTrap;
  wire        protTrap;
  wire        mmuTrap;
  wire        virtSeg;
  wire        accept;
  wire [63:0] extData;
  reg  [7:0]  bitByte;

  assign shortOff = {{22{reqOffset[9]}}, reqOffset[9:0]};
  assign longOff  = {{16{reqOffset[15]}}, reqOffset};

  // Effective address and address-register update per mode
  always @* begin
    effAddr  = reqBase;
    newBase  = reqBase;
    usesDisp = 1'b0;
    case (reqMode) // [R20]
      `LSAC_MODE_ABS: begin
        effAddr = {reqAbs[17:14], 14'h0000, reqAbs[13:0]}; // [R12]
      end
      `LSAC_MODE_SHORT: begin
        effAddr  = reqBase + shortOff; // [R2]
        usesDisp = 1'b1;
      end
      `LSAC_MODE_LONG: begin
        effAddr  = reqBase + longOff;
        usesDisp = 1'b1;
      end
      `LSAC_MODE_PRE: begin
        effAddr  = reqBase + shortOff;
        newBase  = reqBase + shortOff;
        usesDisp = 1'b1;
      end
      `LSAC_MODE_POST: begin
        newBase = reqBase + shortOff;
      end
      `LSAC_MODE_CIRC, `LSAC_MODE_BREV: begin
        effAddr  = reqBase + {16'h0000, reqIndex};
        usesDisp = 1'b1;
      end
      default: begin
        effAddr = reqBase;
      end
    endcase
  end

  assign reqSeg = effAddr[31:28]; // [R11]
  assign crossTrap = usesDisp & (reqSeg != reqBase[31:28]); // [R13]

  assign isAtomic = (reqKind == `LSAC_KIND_LMS) |
                    (reqKind == `LSAC_KIND_SWAP) |
                    (reqKind == `LSAC_KIND_BIT_ST);
  assign isCtx    = (reqKind == `LSAC_KIND_CTX_LD) |
                    (reqKind == `LSAC_KIND_CTX_ST);
  assign isLoad   = (reqKind == `LSAC_KIND_LD_DATA) |
                    (reqKind == `LSAC_KIND_LD_ADDR) |
                    (reqKind == `LSAC_KIND_CTX_LD);

  // Alignment demand by kind and size
  always @* begin
    case (reqKind)
      `LSAC_KIND_LD_DATA, `LSAC_KIND_ST_DATA: begin
        if (reqSize == `LSAC_SIZE_BYTE) begin
          alnBad = 1'b0; // [R6]
        end else if ((reqSize == `LSAC_SIZE_DBL) &&
                     (reqSeg >= `LSAC_SEG_PERIPH_LO)) begin
          alnBad = |(effAddr[5:0] & `LSAC_ALN_WORD); // [R8]
        end else begin
          alnBad = |(effAddr[5:0] & `LSAC_ALN_HALF); // [R6]
        end
      end
      `LSAC_KIND_LD_ADDR, `LSAC_KIND_ST_ADDR: begin
        alnBad = |(effAddr[5:0] & `LSAC_ALN_WORD); // [R5]
      end
      `LSAC_KIND_LMS, `LSAC_KIND_SWAP: begin
        alnBad = |(effAddr[5:0] & `LSAC_ALN_WORD); // [R7]
      end
      `LSAC_KIND_BIT_ST: begin
        alnBad = 1'b0; // [R6]
      end
      `LSAC_KIND_CTX_LD, `LSAC_KIND_CTX_ST: begin
        alnBad = |(effAddr[5:0] & `LSAC_ALN_CTX); // [R9]
      end
      default: begin
        alnBad = 1'b0;
      end
    endcase
  end

  assign privTrap = (reqSeg == `LSAC_SEG_PERIPH_NS) &
                    (privMode == `LSAC_PRIV_USER0); // [R15]
  assign protTrap = protEnable & isAtomic & ~(protRead & protWrite); // [R19]
  assign virtSeg  = (reqSeg <= `LSAC_SEG_LAST_VIRT);
  assign mmuTrap  = virtSeg & ~MMU_PRESENT & NOMMU_TRAP; // [R14]
  assign accept   = reqValid & reqReady_q;

  // Atomic bit store edits one bit of the fetched byte
  always @* begin
    bitByte = busRdata[7:0];
    bitByte[bitPos_q] = bitVal_q;
  end

  lsac_extend u_extend (
    .rawData  (busRdata),
    .accSize  (size_q),
    .signExt  (signed_q),
    .fracLoad (frac_q),
    .extData  (extData)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_IDLE;
      kind_q       <= 4'h0;
      size_q       <= 2'h0;
      signed_q     <= 1'b0;
      frac_q       <= 1'b0;
      src_q        <= 64'h0000000000000000;
      mask_q       <= 32'h00000000;
      bitVal_q     <= 1'b0;
      bitPos_q     <= 3'h0;
      reqReady_q   <= 1'b0;
      respValid_q  <= 1'b0;
      respWrite_q  <= 1'b0;
      respData_q   <= 64'h0000000000000000;
      respBase_q   <= 32'h00000000;
      ctxIndex_q   <= 4'h0;
      respRetry_q  <= 1'b0;
      trapValid_q  <= 1'b0;
      trapCause_q  <= `LSAC_TRAP_NONE;
      busReq_q     <= 1'b0;
      busWe_q      <= 1'b0;
      busAddr_q    <= 32'h00000000;
      busSize_q    <= 2'h0;
      busWdata_q   <= 64'h0000000000000000;
      busLock_q    <= 1'b0;
      busNonSpec_q <= 1'b0;
      busVirtual_q <= 1'b0;
      busCsfr_q    <= 1'b0;
    end else begin
      respValid_q <= 1'b0;
      respWrite_q <= 1'b0;
      respRetry_q <= 1'b0;
      trapValid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          reqReady_q <= 1'b1;
          if (accept) begin
            respBase_q <= newBase;
            // Priority: segment cross, alignment, privilege, protection, MMU
            if (crossTrap) begin
              trapValid_q <= 1'b1; // [R13]
              trapCause_q <= `LSAC_TRAP_MEM;
            end else if (alnBad) begin
              trapValid_q <= 1'b1; // [R21]
              trapCause_q <= `LSAC_TRAP_ALN;
            end else if (privTrap) begin
              trapValid_q <= 1'b1; // [R15]
              trapCause_q <= `LSAC_TRAP_PRIV;
            end else if (protTrap) begin
              trapValid_q <= 1'b1; // [R19]
              trapCause_q <= `LSAC_TRAP_PROT;
            end else if (mmuTrap) begin
              trapValid_q <= 1'b1; // [R14]
              trapCause_q <= `LSAC_TRAP_MMU;
            end else if (reqSpec && (reqSeg == `LSAC_SEG_PERIPH_NS)) begin
              respRetry_q <= 1'b1; // [R15]
            end else begin
              reqReady_q   <= 1'b0;
              kind_q       <= reqKind;
              signed_q     <= reqSigned;
              frac_q       <= reqFrac;
              src_q        <= reqData;
              mask_q       <= reqMask;
              bitVal_q     <= |reqBitSrc; // [R1]
              bitPos_q     <= reqBitPos;
              ctxIndex_q   <= 4'h0;
              busReq_q     <= 1'b1;
              busAddr_q    <= effAddr;
              busLock_q    <= isAtomic;
              busNonSpec_q <= (reqSeg == `LSAC_SEG_PERIPH_NS); // [R15]
              busVirtual_q <= virtSeg & MMU_PRESENT & mmuEnable; // [R14]
              busCsfr_q    <= (effAddr[31:16] == CORE_SPECIAL_REGISTERS_BASE); // [R16]
              if (isCtx) begin
                size_q    <= `LSAC_SIZE_WORD; // [R9]
                busSize_q <= `LSAC_SIZE_WORD;
              end else if (isAtomic) begin
                size_q    <= (reqKind == `LSAC_KIND_BIT_ST) ?
                             `LSAC_SIZE_BYTE : `LSAC_SIZE_WORD;
                busSize_q <= (reqKind == `LSAC_KIND_BIT_ST) ?
                             `LSAC_SIZE_BYTE : `LSAC_SIZE_WORD;
              end else begin
                size_q    <= reqSize;
                busSize_q <= reqSize;
              end
              if (isLoad || isAtomic) begin
                busWe_q <= 1'b0;
                state_q <= ST_READ;
              end else begin
                busWe_q  <= 1'b1;
                busReq_q <= ~isCtx;
                // Low word at the low address
                busWdata_q <= isCtx ? {32'h00000000, ctxData} : reqData;
                state_q    <= ST_WRITE; // [R10]
              end
            end
          end
        end
        ST_READ: begin
          if (busAck) begin
            busReq_q <= 1'b0;
            case (kind_q)
              `LSAC_KIND_LMS: begin
                busReq_q   <= 1'b1;
                busWe_q    <= 1'b1;
                busWdata_q <= {32'h00000000,
                               (busRdata[31:0] & ~mask_q) |
                               (src_q[31:0] & mask_q)}; // [R17]
                state_q    <= ST_WRITE;
              end
              `LSAC_KIND_SWAP: begin
                busReq_q   <= 1'b1;
                busWe_q    <= 1'b1;
                busWdata_q <= {32'h00000000, src_q[31:0]}; // [R18]
                respData_q <= {32'h00000000, busRdata[31:0]};
                state_q    <= ST_WRITE;
              end
              `LSAC_KIND_BIT_ST: begin
                busReq_q   <= 1'b1;
                busWe_q    <= 1'b1;
                busWdata_q <= {56'h00000000000000, bitByte};
                state_q    <= ST_WRITE;
              end
              `LSAC_KIND_CTX_LD: begin
                respValid_q <= 1'b1;
                respWrite_q <= 1'b1;
                respData_q  <= {32'h00000000, busRdata[31:0]};
                if (ctxIndex_q == `LSAC_CTX_LAST) begin
                  reqReady_q <= 1'b1;
                  state_q    <= ST_IDLE;
                end else begin
                  busReq_q   <= 1'b1;
                  busAddr_q  <= busAddr_q + `LSAC_WORD_STEP;
                  ctxIndex_q <= ctxIndex_q + 4'h1;
                end
              end
              default: begin
                respValid_q <= 1'b1;
                respWrite_q <= 1'b1;
                respData_q  <= extData; // [R3]
                reqReady_q  <= 1'b1;
                state_q     <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WRITE: begin
          if (!busReq_q) begin
            // Context word fetched once ctxIndex_q names this beat
            busReq_q   <= 1'b1;
            busWdata_q <= {32'h00000000, ctxData};
          end else if (busAck) begin
            busReq_q <= 1'b0;
            if ((kind_q == `LSAC_KIND_CTX_ST) &&
                (ctxIndex_q != `LSAC_CTX_LAST)) begin
              busAddr_q  <= busAddr_q + `LSAC_WORD_STEP;
              ctxIndex_q <= ctxIndex_q + 4'h1;
            end else begin
              busLock_q   <= 1'b0;
              respValid_q <= 1'b1;
              // Only swap hands a value back to the register file
              respWrite_q <= (kind_q == `LSAC_KIND_SWAP); // [R17]
              reqReady_q  <= 1'b1;
              state_q     <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // lsac_access_check

// ---- dv/lsac_bus_mem.sv ----
// Behavioural memory and peripheral bus answering the access checker.
// Assumes requests held until busAck; answers promptly or two beats late.
`timescale 1ns/1ps
module lsac_bus_mem (
  // Clock, reset and pacing
  input  wire        clk,
  input  wire        reset_n,
  input  wire        slow,
  // Bus request
  input  wire        busReq_q,
  input  wire        busWe_q,
  input  wire [31:0] busAddr_q,
  input  wire [1:0]  busSize_q,
  input  wire [63:0] busWdata_q,
  // Bus answer
  output logic        busAck,
  output logic [63:0] busRdata
);
  logic [7:0] mem [int];
  initial begin
    busAck = 1'b0;
    busRdata = 64'h0;
    forever begin
      @(posedge clk);
      #1;
      busAck = 1'b0;
      // Stale read data never lingers on the bus
      busRdata = ~busRdata;
      if (reset_n === 1'b1 && busReq_q === 1'b1) begin
        repeat (slow ? 2 : 0) begin
          @(posedge clk);
          #1;
          busRdata = ~busRdata;
        end
        for (int i = 0; i < (1 << busSize_q); i++) begin
          if (busWe_q) mem[busAddr_q + i] = busWdata_q[8 * i +: 8];
          else busRdata[8 * i +: 8] = mem.exists(busAddr_q + i) ?
            mem[busAddr_q + i] : 8'hA5;
        end
        busAck = 1'b1;
      end
    end
  end
endmodule // lsac_bus_mem

// ---- dv/lsac_access_check_sva.sv ----
// Port-level checks for the load/store access checker.
// Assumes the shared map header; bound onto every checker instance.
`timescale 1ns/1ps
`include "lsac_map.vh"
module lsac_access_check_sva #(
  parameter        MMU_PRESENT = 1'b1,
  parameter [15:0] CORE_SPECIAL_REGISTERS_BASE   = 16'hF000
) (
  // Clock and reset
  input wire        clk,
  input wire        reset_n,
  // Request side
  input wire        reqValid,
  input wire        reqReady_q,
  input wire [3:0]  reqKind,
  input wire [1:0]  reqSize,
  input wire [2:0]  reqMode,
  input wire [31:0] reqBase,
  input wire [15:0] reqOffset,
  input wire [17:0] reqAbs,
  input wire [1:0]  privMode,
  input wire        mmuEnable,
  // Answers and bus
  input wire        trapValid_q,
  input wire [2:0]  trapCause_q,
  input wire        busReq_q,
  input wire        busAck,
  input wire [31:0] busAddr_q,
  input wire        busNonSpec_q,
  input wire        busVirtual_q,
  input wire        busCsfr_q
);
  wire        take    = reqValid && reqReady_q;
  wire        isPost  = reqMode == `LSAC_MODE_POST;
  wire [31:0] longSum = reqBase + {{16{reqOffset[15]}}, reqOffset};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_seg_cross: assert property (
    take && reqMode == `LSAC_MODE_LONG && longSum[31:28] != reqBase[31:28]
    |=> trapValid_q && trapCause_q == `LSAC_TRAP_MEM)
    else $error("no MEM trap");
  chk_atomic_aln: assert property (
    take && isPost && reqBase[1:0] != 2'h0 &&
    (reqKind == `LSAC_KIND_LMS || reqKind == `LSAC_KIND_SWAP)
    |=> trapValid_q && trapCause_q == `LSAC_TRAP_ALN && !busReq_q)
    else $error("atomic ALN");
  chk_ctx_aln: assert property (
    take && isPost && reqBase[5:0] != 6'h0 &&
    (reqKind == `LSAC_KIND_CTX_LD || reqKind == `LSAC_KIND_CTX_ST)
    |=> trapValid_q && trapCause_q == `LSAC_TRAP_ALN)
    else $error("context ALN");
  chk_abs_addr: assert property (
    take && reqMode == `LSAC_MODE_ABS && reqKind == `LSAC_KIND_LD_DATA &&
    reqSize == `LSAC_SIZE_BYTE && privMode == `LSAC_PRIV_SUPER &&
    reqAbs[17:14] >= 4'h8 && reqAbs[17:14] <= 4'hD
    |=> busReq_q && busAddr_q ==
      {$past(reqAbs[17:14]), 14'h0, $past(reqAbs[13:0])})
    else $error("abs address");
  chk_user0_priv: assert property (
    take && isPost && reqBase[31:28] == `LSAC_SEG_PERIPH_NS &&
    reqBase[1:0] == 2'h0 && reqKind == `LSAC_KIND_LD_DATA &&
    privMode == `LSAC_PRIV_USER0
    |=> trapValid_q && trapCause_q == `LSAC_TRAP_PRIV)
    else $error("user-0 in F");
  chk_nonspec_seg: assert property (
    busReq_q && busAddr_q[31:28] == `LSAC_SEG_PERIPH_NS |-> busNonSpec_q)
    else $error("F speculative");
  chk_virt_seg: assert property (
    busReq_q |-> busVirtual_q == ((MMU_PRESENT != 0) && mmuEnable &&
      busAddr_q[31:28] <= `LSAC_SEG_LAST_VIRT))
    else $error("virtual flag");
  chk_core_special_registers_window: assert property (
    busReq_q |-> busCsfr_q == (busAddr_q[31:16] == CORE_SPECIAL_REGISTERS_BASE))
    else $error("core_special_registers flag");
  chk_bus_hold: assert property (
    busReq_q && !busAck |=> busReq_q && $stable(busAddr_q))
    else $error("bus not held");
  chk_trap_quiet: assert property (
    trapValid_q |-> !busReq_q && reqReady_q)
    else $error("trap hit bus");
endmodule // lsac_access_check_sva

bind lsac_access_check lsac_access_check_sva #(
  .MMU_PRESENT(MMU_PRESENT), .CORE_SPECIAL_REGISTERS_BASE(CORE_SPECIAL_REGISTERS_BASE)) u_sva (.*);

// ---- dv/tb_top.sv ----
// Self-checking bench for the load/store access checker.
// Assumes the map header and the behavioural bus memory beside it.
`timescale 1ns/1ps
`include "lsac_map.vh"
module tb_top;
  typedef struct packed {
    logic [1:0]  ev;
    logic [2:0]  cause;
    logic        cw;
    logic        wr;
    logic [63:0] data;
    logic [63:0] mask;
  } lsac_exp_t;
  localparam [3:0] LD = `LSAC_KIND_LD_DATA;
  localparam [2:0] PO = `LSAC_MODE_POST;
  localparam [63:0] LW = 64'hFFFFFFFF;
  logic        clk, reset_n, reqValid, reqSigned, reqFrac, reqSpec, slow;
  logic        mmuEnable, protEnable, protRead, protWrite;
  logic [3:0]  reqKind;
  logic [1:0]  reqSize, privMode;
  logic [2:0]  reqMode, reqBitPos;
  logic [15:0] reqOffset, reqIndex;
  logic [17:0] reqAbs;
  logic [31:0] reqBase, reqMask, reqBitSrc, lfsrV;
  logic [63:0] reqData, dv, sv;
  wire         reqReady_q, respValid_q, respWrite_q, respRetry_q, busAck;
  wire         trapValid_q, busReq_q, busWe_q, busLock_q, busNonSpec_q;
  wire         busVirtual_q, busCsfr_q;
  wire [2:0]   trapCause_q;
  wire [3:0]   ctxIndex_q;
  wire [1:0]   busSize_q;
  wire [31:0]  respBase_q, busAddr_q, ctxData;
  wire [63:0]  respData_q, busWdata_q, busRdata;
  int          fails, total_checks, cyc;
  lsac_exp_t   exq[$];
  lsac_exp_t   e;
  logic [43:0] tab [10] = '{44'h22190000202, 44'h33190000206,
    44'h12090000202, 44'h131E0000202, 44'h13090000206, 44'h42190000202,
    44'h52190000201, 44'h82190000220, 44'h60090000203, 44'h00090000201};

  assign ctxData = {28'hC0DE5A0, ctxIndex_q};
  lsac_access_check uut (.*);
  lsac_bus_mem mem_i (.*);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic roll;
    repeat (32) lfsrV = lfsr(lfsrV);
  endtask
  task automatic chk(input [64:0] got, input [64:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ex(input [1:0] ev, input [2:0] c, input cw, input wr,
                    input [63:0] d, input [63:0] m);
    exq.push_back({ev, c, cw, wr, d, m});
  endtask
  task automatic go(input [3:0] k, input [1:0] s, input [2:0] m,
                    input [31:0] a);
    reqKind = k;
    reqSize = s;
    reqMode = m;
    reqBase = a;
    roll();
    slow = lfsrV[0];
    reqValid = 1'b1;
    do @(negedge clk); while (reqReady_q !== 1'b1);
    @(posedge clk);
    #1 reqValid = 1'b0;
    while (exq.size() != 0) @(posedge clk);
    @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk)
    if (reset_n === 1'b1 && (respValid_q | trapValid_q | respRetry_q)) begin
      if (exq.size() == 0) chk(65'h1, 65'h0);
      else begin
        e = exq.pop_front();
        chk(65'({trapValid_q, respRetry_q}), 65'(e.ev));
        if (e.ev[1]) chk(65'(trapCause_q), 65'(e.cause));
        if (e.cw) chk(65'(respWrite_q), 65'(e.wr));
        if (e.mask != 0) chk(65'(respData_q & e.mask), 65'(e.data));
      end
    end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end

  initial begin
    {reset_n, reqValid, reqSigned, reqFrac, reqSpec, slow} = 6'h00;
    {mmuEnable, protEnable, protRead, protWrite} = 4'h0;
    {reqKind, reqSize, reqMode, reqBitPos, reqOffset, reqIndex} = 0;
    {reqAbs, reqBase, reqMask, reqBitSrc, reqData} = 0;
    privMode = `LSAC_PRIV_SUPER;
    lfsrV = 32'd50959;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    roll();
    dv[31:0] = lfsrV;
    roll();
    dv[63:32] = lfsrV | 32'h80000000;
    reqData = dv;
    ex(0, 0, 0, 0, 0, 0);
    go(`LSAC_KIND_ST_DATA, `LSAC_SIZE_DBL, PO, 32'h90000100);
    ex(0, 0, 1, 1, dv[47:16], LW);
    go(LD, `LSAC_SIZE_WORD, PO, 32'h90000102);
    reqSigned = 1'b1;
    ex(0, 0, 1, 1, {{16{dv[63]}}, dv[63:48]}, LW);
    go(LD, `LSAC_SIZE_HALF, PO, 32'h90000106);
    ex(0, 0, 1, 1, {{24{dv[63]}}, dv[63:56]}, LW);
    go(LD, `LSAC_SIZE_BYTE, PO, 32'h90000107);
    {reqSigned, reqFrac} = 2'b01;
    ex(0, 0, 1, 1, {dv[63:48], 16'h0}, LW);
    go(LD, `LSAC_SIZE_HALF, PO, 32'h90000106);
    reqFrac = 1'b0;
    ex(0, 0, 1, 1, dv[63:56], LW);
    go(LD, `LSAC_SIZE_BYTE, PO, 32'h90000107);
    $display("test extension done");
    for (int i = 0; i < 10; i++) begin
      ex(tab[i][32] ? 2'b10 : 2'b00, `LSAC_TRAP_ALN, 0, 0, 0, 0);
      go(tab[i][43:40], tab[i][37:36], PO, tab[i][31:0]);
    end
    $display("test alignment done");
    reqOffset = 16'h0020;
    ex(2'b10, `LSAC_TRAP_MEM, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_BYTE, `LSAC_MODE_LONG, 32'h9FFFFFF0);
    reqOffset = 16'h03F0;
    ex(2'b10, `LSAC_TRAP_MEM, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_BYTE, `LSAC_MODE_SHORT, 32'hA0000004);
    reqOffset = 16'h0000;
    reqIndex = 16'h0004;
    ex(2'b10, `LSAC_TRAP_MEM, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_BYTE, `LSAC_MODE_CIRC, 32'h9FFFFFFE);
    reqIndex = 16'h0000;
    for (int m = 1; m < 7; m++) begin
      ex(0, 0, 0, 0, 0, 0);
      go(LD, `LSAC_SIZE_BYTE, m[2:0], 32'h90000100);
    end
    $display("test segments done");
    privMode = `LSAC_PRIV_USER0;
    ex(2'b10, `LSAC_TRAP_PRIV, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_WORD, PO, 32'hF0000000);
    {privMode, reqSpec} = {`LSAC_PRIV_USER1, 1'b1};
    ex(2'b01, 0, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_WORD, PO, 32'hF0000000);
    reqSpec = 1'b0;
    ex(0, 0, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_WORD, PO, 32'hF0000000);
    privMode = `LSAC_PRIV_SUPER;
    mmuEnable = 1'b1;
    ex(0, 0, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_BYTE, PO, 32'h20000010);
    mmuEnable = 1'b0;
    reqAbs = 18'h20123;
    ex(0, 0, 0, 0, 0, 0);
    go(LD, `LSAC_SIZE_BYTE, `LSAC_MODE_ABS, 32'h0);
    $display("test privilege done");
    roll();
    sv = {32'h0, lfsrV & 32'hFFFFF7FF};
    reqData = sv;
    ex(0, 0, 1, 1, dv[31:0], LW);
    go(`LSAC_KIND_SWAP, `LSAC_SIZE_WORD, PO, 32'h90000100);
    roll();
    reqMask = lfsrV;
    roll();
    reqData = {32'h0, lfsrV};
    sv[31:0] = (sv[31:0] & ~reqMask) | (lfsrV & reqMask);
    sv[11] = 1'b1;
    ex(0, 0, 1, 0, 0, 0);
    go(`LSAC_KIND_LMS, `LSAC_SIZE_WORD, PO, 32'h90000100);
    {reqBitPos, reqBitSrc} = {3'h3, 32'h00000100};
    ex(0, 0, 0, 0, 0, 0);
    go(`LSAC_KIND_BIT_ST, `LSAC_SIZE_BYTE, PO, 32'h90000101);
    ex(0, 0, 1, 1, sv[31:0], LW);
    go(LD, `LSAC_SIZE_WORD, PO, 32'h90000100);
    {protEnable, protRead, protWrite} = 3'b110;
    ex(2'b10, `LSAC_TRAP_PROT, 0, 0, 0, 0);
    go(`LSAC_KIND_SWAP, `LSAC_SIZE_WORD, PO, 32'h90000100);
    protWrite = 1'b1;
    ex(0, 0, 0, 0, 0, 0);
    go(`LSAC_KIND_SWAP, `LSAC_SIZE_WORD, PO, 32'h90000100);
    protEnable = 1'b0;
    $display("test atomics done");
    ex(0, 0, 0, 0, 0, 0);
    go(`LSAC_KIND_CTX_ST, `LSAC_SIZE_WORD, PO, 32'h90000400);
    for (int i = 0; i < 16; i++)
      ex(0, 0, 1, 1, {28'hC0DE5A0, i[3:0]}, LW);
    go(`LSAC_KIND_CTX_LD, `LSAC_SIZE_WORD, PO, 32'h90000400);
    $display("test context done");
    results();
  end
endmodule // tb_top
